/* File: rtl/iex_pkg.sv */
// Purpose: Shared constants and types for the instruction execution subset
// Assumes: 8-bit data path, 5-bit file address, one instruction per enable
// Notes:   Flag positions follow the usual status layout of this core
package iex_pkg;
  // ==========================================================
  // Widths
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FADDR_W    = 5;
  // ==========================================================
  // Status bit positions
  localparam int unsigned ST_CARRY   = 0;
  localparam int unsigned ST_HALF    = 1;
  localparam int unsigned ST_ZERO    = 2;
  localparam int unsigned ST_PDOWN   = 3;
  localparam int unsigned ST_WDEXP   = 4;
  localparam int unsigned ST_PINWAKE = 7;
  // ==========================================================
  // Reset values
  localparam logic [7:0] W_RESET     = 8'h00;
  localparam logic [7:0] DIR_RESET   = 8'hFF;
  localparam logic [7:0] STAT_RESET  = 8'h18;
  localparam logic [7:0] WD_CLEAR    = 8'h00;
  // ==========================================================
  // Direction register select codes
  localparam logic [4:0] DIR_PORT_A  = 5'h06;
  localparam logic [4:0] DIR_PORT_B  = 5'h07;
  localparam logic [4:0] DIR_PORT_C  = 5'h08;
  // Destination select
  localparam logic DEST_W    = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  // ==========================================================
  // Operation codes from the decoder
  typedef enum logic [2:0] {
    IEX_OP_NONE   = 3'h0,
    IEX_OP_RRC    = 3'h1,
    IEX_OP_SUB    = 3'h2,
    IEX_OP_SWAP   = 3'h3,
    IEX_OP_DIR    = 3'h4,
    IEX_OP_XORL   = 3'h5,
    IEX_OP_SLEEP  = 3'h6
  } iex_op_type;
  // Core run state
  typedef enum logic [1:0] {
    IEX_RUN   = 2'b01,
    IEX_SLEEP = 2'b10
  } iex_state_type;
endpackage : iex_pkg

/* File: rtl/iex_alu.sv */
// Purpose: Combinational result and flag unit for the execution subset
// Assumes: Operands are stable for the whole instruction cycle
// Notes:   Flags are produced for every op; the caller decides which to keep
`timescale 1ns/100ps
`default_nettype none
module iex_alu (
  input  wire iex_pkg::iex_op_type op,
  input  wire logic [7:0]          file_val,
  input  wire logic [7:0]          w_val,
  input  wire logic [7:0]          literal,
  input  wire logic                carry_in,
  output logic [7:0]               result,
  output logic                     carry_out,
  output logic                     half_out,
  output logic                     zero_out
);
  logic [8:0] diff;
  logic [4:0] ndiff;
  // Two's complement: f + ~w + 1, so carry out means no borrow
  assign diff  = {1'b0, file_val} + {1'b0, ~w_val} + 9'h001;
  assign ndiff = {1'b0, file_val[3:0]} + {1'b0, ~w_val[3:0]} + 5'h01;
  always_comb begin
    result    = file_val;
    carry_out = carry_in;
    unique case (op)
      iex_pkg::IEX_OP_RRC: begin
        result    = {carry_in, file_val[7:1]}; // RULE1
        carry_out = file_val[0];               // RULE1
      end
      iex_pkg::IEX_OP_SUB: begin
        result    = diff[7:0];                 // RULE3
        carry_out = diff[8];                   // RULE10
      end
      iex_pkg::IEX_OP_SWAP: result = {file_val[3:0], file_val[7:4]}; // RULE4
      iex_pkg::IEX_OP_XORL: result = w_val ^ literal;                // RULE6
      default: result = w_val;
    endcase
  end
  assign half_out = ndiff[4];
  assign zero_out = (result == 8'h00);
endmodule : iex_alu
`default_nettype wire

/* File: rtl/iex_exec.sv */
// Purpose: Execution of rotate, subtract, swap, xor-literal, direction load and sleep
// Assumes: Decoder presents one op with exec_en for one cycle per instruction
// Notes:   File register write-back goes out on file_we with file_wdata
//
// Overview of operation
// RULE1 - Rotate right: old carry into bit 7, bit 0 becomes carry, only carry changes
// RULE2 - Destination bit 0 writes working register, 1 writes file register 0..31
// RULE3 - Subtract computes file minus working register, updates carry, half carry, zero
// RULE4 - Nibble swap exchanges high and low nibbles, no flags change
// RULE5 - Direction load copies working register to port 6, 7 or 8, no flags
// RULE6 - Xor literal combines W with 8-bit literal into W, only zero changes
// RULE7 - Sleep clears watchdog counter to zero and its prescaler
// RULE8 - Sleep sets watchdog expiry flag, clears power-down flag, keeps pin wake
// RULE9 - After sleep no instruction executes until wake-up
// RULE10 - Subtract carry is one without borrow; zero set on zero result
// RULE11 - Xor literal sets zero on all-zero result, clears otherwise
`timescale 1ns/100ps
`default_nettype none
module iex_exec (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                exec_en,
  input  wire iex_pkg::iex_op_type op,
  input  wire logic [4:0]          file_addr,
  input  wire logic                dest_sel,
  input  wire logic [7:0]          literal,
  input  wire logic [7:0]          file_rdata,
  input  wire logic                wake_up,
  input  wire logic                pin_wake_set,
  output logic [7:0]               file_wdata,
  output logic                     file_we,
  output logic [7:0]               w_reg,
  output logic [7:0]               status,
  output logic [7:0]               dir_a,
  output logic [7:0]               dir_b,
  output logic [7:0]               dir_c,
  output logic                     watchdog_clear,
  output logic                     sleeping,
  output logic                     osc_halt
);
  // ==========================================================
  // Run state
  iex_pkg::iex_state_type state_r;
  logic [7:0] w_r, status_r, dir_a_r, dir_b_r, dir_c_r, file_wdata_r;
  logic       file_we_r, watchdog_clear_r;
  logic [7:0] alu_res;
  logic       alu_c, alu_half, alu_z, go, to_file;

  // Instructions are ignored while asleep
  assign go = exec_en && (state_r == iex_pkg::IEX_RUN); // RULE9

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= iex_pkg::IEX_RUN;
    end else begin
      unique case (state_r)
        iex_pkg::IEX_RUN:
          if (go && op == iex_pkg::IEX_OP_SLEEP) state_r <= iex_pkg::IEX_SLEEP; // RULE9
        iex_pkg::IEX_SLEEP:
          if (wake_up) state_r <= iex_pkg::IEX_RUN;
        default: state_r <= iex_pkg::IEX_RUN;
      endcase
    end
  end
  assign sleeping = (state_r == iex_pkg::IEX_SLEEP);
  assign osc_halt = sleeping; // RULE9

  // ==========================================================
  // Arithmetic
  iex_alu u_alu (
    .op        (op),
    .file_val  (file_rdata),
    .w_val     (w_r),
    .literal   (literal),
    .carry_in  (status_r[iex_pkg::ST_CARRY]),
    .result    (alu_res),
    .carry_out (alu_c),
    .half_out  (alu_half),
    .zero_out  (alu_z)
  );

  assign to_file = (op == iex_pkg::IEX_OP_RRC || op == iex_pkg::IEX_OP_SUB ||
                    op == iex_pkg::IEX_OP_SWAP);

  // ==========================================================
  // Working register and file write-back
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      w_r          <= iex_pkg::W_RESET;
      file_we_r    <= 1'b0;
      file_wdata_r <= 8'h00;
    end else begin
      file_we_r <= 1'b0;
      if (go && to_file && dest_sel == iex_pkg::DEST_FILE) begin // RULE2
        file_we_r    <= 1'b1;
        file_wdata_r <= alu_res;
      end else if (go && to_file) begin
        w_r <= alu_res; // RULE2
      end else if (go && op == iex_pkg::IEX_OP_XORL) begin
        w_r <= alu_res; // RULE6
      end
    end
  end

  // ==========================================================
  // Direction registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dir_a_r <= iex_pkg::DIR_RESET;
      dir_b_r <= iex_pkg::DIR_RESET;
      dir_c_r <= iex_pkg::DIR_RESET;
    end else if (go && op == iex_pkg::IEX_OP_DIR) begin
      if (file_addr == iex_pkg::DIR_PORT_A) dir_a_r <= w_r; // RULE5
      if (file_addr == iex_pkg::DIR_PORT_B) dir_b_r <= w_r; // RULE5
      if (file_addr == iex_pkg::DIR_PORT_C) dir_c_r <= w_r; // RULE5
    end
  end

  // ==========================================================
  // Status flags; ops not listed leave every flag alone
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= iex_pkg::STAT_RESET;
    end else begin
      if (go) begin
        unique case (op)
          iex_pkg::IEX_OP_RRC: status_r[iex_pkg::ST_CARRY] <= alu_c; // RULE1
          iex_pkg::IEX_OP_SUB: begin
            status_r[iex_pkg::ST_CARRY] <= alu_c;  // RULE3 RULE10
            status_r[iex_pkg::ST_HALF]  <= alu_half; // RULE3
            status_r[iex_pkg::ST_ZERO]  <= alu_z;  // RULE10
          end
          iex_pkg::IEX_OP_XORL: status_r[iex_pkg::ST_ZERO] <= alu_z; // RULE11
          iex_pkg::IEX_OP_SLEEP: begin
            status_r[iex_pkg::ST_WDEXP] <= 1'b1; // RULE8
            status_r[iex_pkg::ST_PDOWN] <= 1'b0; // RULE8
          end
          default: ;
        endcase
      end
      // Hardware wake event wins over anything else on this bit
      if (pin_wake_set) status_r[iex_pkg::ST_PINWAKE] <= 1'b1;
    end
  end

  // ==========================================================
  // Watchdog clear pulse
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) watchdog_clear_r <= 1'b0;
    else        watchdog_clear_r <= go && (op == iex_pkg::IEX_OP_SLEEP); // RULE7
  end

  assign w_reg      = w_r;
  assign status     = status_r;
  assign dir_a      = dir_a_r;
  assign dir_b      = dir_b_r;
  assign dir_c      = dir_c_r;
  assign file_we    = file_we_r;
  assign file_wdata = file_wdata_r;
  assign watchdog_clear = watchdog_clear_r;

  // ==========================================================
  // Checks
  a_sleep_blocks: assert property (@(posedge clock) disable iff (!rst_n) // RULE9
    sleeping && exec_en |=> $stable(w_r) && !file_we_r)
    else $error("instruction executed while asleep");
  a_sleep_flags: assert property (@(posedge clock) disable iff (!rst_n) // RULE8
    go && op == iex_pkg::IEX_OP_SLEEP && !pin_wake_set |=>
      status_r[iex_pkg::ST_WDEXP] && !status_r[iex_pkg::ST_PDOWN] &&
      $stable(status_r[iex_pkg::ST_PINWAKE]))
    else $error("sleep flags wrong");
  a_watchdog_clear: assert property (@(posedge clock) disable iff (!rst_n) // RULE7
    go && op == iex_pkg::IEX_OP_SLEEP |=> watchdog_clear && sleeping)
    else $error("watchdog not cleared on sleep");
  // A stretched clear would hold the watchdog at zero past the sleep entry
  a_clear_pulse: assert property (@(posedge clock) disable iff (!rst_n) // RULE7
    watchdog_clear |=> !watchdog_clear)
    else $error("watchdog clear longer than one cycle");
  a_rrc_result: assert property (@(posedge clock) disable iff (!rst_n) // RULE1
    go && op == iex_pkg::IEX_OP_RRC && dest_sel == iex_pkg::DEST_W |=>
      w_r == {$past(status_r[0]), $past(file_rdata[7:1])} &&
      status_r[0] == $past(file_rdata[0]))
    else $error("rotate result wrong");
  // Write-back data gets its own checks, as a W-only check misses a lost file write
  a_rrc_file: assert property (@(posedge clock) disable iff (!rst_n) // RULE1
    go && op == iex_pkg::IEX_OP_RRC && dest_sel == iex_pkg::DEST_FILE |=>
      file_wdata == {$past(status_r[0]), $past(file_rdata[7:1])} &&
      status_r[0] == $past(file_rdata[0]) && $stable(status_r[2:1]))
    else $error("rotate to file wrong");
  a_dest_file: assert property (@(posedge clock) disable iff (!rst_n) // RULE2
    go && to_file && dest_sel == iex_pkg::DEST_FILE |=> file_we && $stable(w_r))
    else $error("file destination not written");
  a_sub_flags: assert property (@(posedge clock) disable iff (!rst_n) // RULE10
    go && op == iex_pkg::IEX_OP_SUB && dest_sel == iex_pkg::DEST_W |=>
      w_r == $past(file_rdata) - $past(w_r) &&
      status_r[0] == ($past(file_rdata) >= $past(w_r)) &&
      status_r[2] == (w_r == 8'h00))
    else $error("subtract result or flags wrong");
  a_sub_file: assert property (@(posedge clock) disable iff (!rst_n) // RULE3
    go && op == iex_pkg::IEX_OP_SUB && dest_sel == iex_pkg::DEST_FILE |=>
      file_wdata == $past(file_rdata) - $past(w_r) && $stable(w_r) &&
      status_r[1] == ($past(file_rdata[3:0]) >= $past(w_r[3:0])))
    else $error("subtract to file wrong");
  a_swap_flags: assert property (@(posedge clock) disable iff (!rst_n) // RULE4
    go && op == iex_pkg::IEX_OP_SWAP |=> status_r[2:0] == $past(status_r[2:0]))
    else $error("swap changed flags");
  a_swap_result: assert property (@(posedge clock) disable iff (!rst_n) // RULE4
    go && op == iex_pkg::IEX_OP_SWAP && dest_sel == iex_pkg::DEST_W |=>
      w_r == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
    else $error("swap result wrong");
  a_dir_load: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
    go && op == iex_pkg::IEX_OP_DIR && file_addr == iex_pkg::DIR_PORT_B |=>
      dir_b == $past(w_r) && $stable(status_r[2:0]))
    else $error("direction load wrong");
  a_dir_other: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
    go && op == iex_pkg::IEX_OP_DIR && file_addr != iex_pkg::DIR_PORT_A &&
      file_addr != iex_pkg::DIR_PORT_B && file_addr != iex_pkg::DIR_PORT_C |=>
      $stable(dir_a_r) && $stable(dir_b_r) && $stable(dir_c_r))
    else $error("direction load with other code changed a port");
  a_xor_zero: assert property (@(posedge clock) disable iff (!rst_n) // RULE6 RULE11
    go && op == iex_pkg::IEX_OP_XORL |=>
      w_r == ($past(w_r) ^ $past(literal)) && status_r[2] == (w_r == 8'h00) &&
      $stable(status_r[1:0]))
    else $error("xor literal wrong");
  a_wake_resume: assert property (@(posedge clock) disable iff (!rst_n) // RULE9
    sleeping && wake_up |=> !sleeping && !osc_halt)
    else $error("wake-up did not leave sleep");
endmodule : iex_exec
`default_nettype wire

/* File: sim/iex_exec_tb.sv */
// Purpose: Self-checking bench for the execution subset
// Assumes: Bench stands in for decoder, register file, wake and pin logic
// Notes:   W is loaded through xor literal, as no plain load op exists here
`timescale 1ns/100ps
`default_nettype none
module iex_exec_tb;
  // ==========================================================
  // Signals
  logic                clock = 1'b0;
  logic                rst_n = 1'b0;
  logic                exec_en = 1'b0;
  iex_pkg::iex_op_type op = iex_pkg::IEX_OP_NONE;
  logic [4:0]          file_addr = 5'h00;
  logic                dest_sel = 1'b0;
  logic [7:0]          literal = 8'h00;
  logic [7:0]          file_rdata = 8'h00;
  logic                wake_up = 1'b0;
  logic                pin_wake_set = 1'b0;
  logic [7:0]          file_wdata, w_reg, status, dir_a, dir_b, dir_c;
  logic                file_we, watchdog_clear, sleeping, osc_halt;
  logic [7:0]          ew, es, r;
  int                  fail_count = 0;
  int                  compares = 0;
  always #10 clock = ~clock;
  iex_exec dut (.clock(clock), .rst_n(rst_n), .exec_en(exec_en), .op(op),
    .file_addr(file_addr), .dest_sel(dest_sel), .literal(literal), .file_rdata(file_rdata),
    .wake_up(wake_up), .pin_wake_set(pin_wake_set), .file_wdata(file_wdata),
    .file_we(file_we), .w_reg(w_reg), .status(status), .dir_a(dir_a), .dir_b(dir_b),
    .dir_c(dir_c), .watchdog_clear(watchdog_clear), .sleeping(sleeping), .osc_halt(osc_halt));
  // ==========================================================
  // Shared tasks
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  // One instruction, then compare W, status and the write-back pulse
  task automatic run(input iex_pkg::iex_op_type o, input logic [4:0] a, input logic d,
                     input logic [7:0] k, input logic [7:0] f, input logic [7:0] wd);
    @(posedge clock);
    exec_en <= 1'b1; op <= o; file_addr <= a; dest_sel <= d; literal <= k; file_rdata <= f;
    @(posedge clock);
    exec_en <= 1'b0;
    @(negedge clock);
    check("w_reg", w_reg, ew);
    check("status", status, es);
    check("file_we", {7'h00, file_we}, {7'h00, d});
    if (d) check("file_wdata", file_wdata, wd);
  endtask : run
  // Expected W must be updated before run compares it
  task automatic set_w(input logic [7:0] v);
    logic [7:0] k;
    k = v ^ ew;
    ew = v;
    es[iex_pkg::ST_ZERO] = (v == 8'h00);
    run(iex_pkg::IEX_OP_XORL, 5'h00, 1'b0, k, 8'h00, 8'h00);
  endtask : set_w
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check("w_reset", w_reg, 8'h00);
    check("stat_reset", status, 8'h18);
    check("dir_reset", dir_a & dir_b & dir_c, 8'hFF);
    check("sleep_reset", {5'h00, watchdog_clear, sleeping, file_we}, 8'h00);
  endtask : t_reset
  task automatic t_xor();
    ew = 8'hA5; es[iex_pkg::ST_ZERO] = 1'b0;
    run(iex_pkg::IEX_OP_XORL, 5'h00, 1'b0, 8'hA5, 8'h00, 8'h00);
    ew = 8'h00; es[iex_pkg::ST_ZERO] = 1'b1;
    run(iex_pkg::IEX_OP_XORL, 5'h00, 1'b0, 8'hA5, 8'h00, 8'h00);
  endtask : t_xor
  task automatic t_rotate(input logic [7:0] f, input logic d);
    r = {es[iex_pkg::ST_CARRY], f[7:1]};
    es[iex_pkg::ST_CARRY] = f[0];
    if (!d) ew = r;
    run(iex_pkg::IEX_OP_RRC, 5'h1F, d, 8'h00, f, r);
  endtask : t_rotate
  task automatic t_sub(input logic [7:0] f, input logic [7:0] w, input logic d);
    set_w(w);
    r = f - w;
    es[iex_pkg::ST_CARRY] = (f >= w);
    es[iex_pkg::ST_HALF] = (f[3:0] >= w[3:0]);
    es[iex_pkg::ST_ZERO] = (r == 8'h00);
    if (!d) ew = r;
    run(iex_pkg::IEX_OP_SUB, 5'h00, d, 8'h00, f, r);
  endtask : t_sub
  task automatic t_swap(input logic d);
    if (!d) ew = 8'hC3;
    run(iex_pkg::IEX_OP_SWAP, 5'h11, d, 8'h00, 8'h3C, 8'hC3);
  endtask : t_swap
  task automatic t_dir();
    // A distinct W per code catches a load routed to the wrong port
    for (int i = 6; i <= 9; i++) begin
      set_w(8'h50 + 8'(i));
      run(iex_pkg::IEX_OP_DIR, 5'(i), 1'b0, 8'h00, 8'h00, 8'h00);
    end
    check("dir_a", dir_a, 8'h56);
    check("dir_b", dir_b, 8'h57);
    check("dir_c", dir_c, 8'h58);
  endtask : t_dir
  task automatic t_sleep();
    @(posedge clock); pin_wake_set <= 1'b1;
    @(posedge clock); pin_wake_set <= 1'b0;
    es[iex_pkg::ST_PINWAKE] = 1'b1;
    es[iex_pkg::ST_WDEXP] = 1'b1;
    es[iex_pkg::ST_PDOWN] = 1'b0;
    run(iex_pkg::IEX_OP_SLEEP, 5'h00, 1'b0, 8'h00, 8'h00, 8'h00);
    check("watchdog_clear", {7'h00, watchdog_clear}, 8'h01);
    check("halt", {6'h00, sleeping, osc_halt}, 8'h03);
    @(negedge clock);
    check("clear_pulse", {7'h00, watchdog_clear}, 8'h00);
    run(iex_pkg::IEX_OP_XORL, 5'h00, 1'b0, 8'hFF, 8'h00, 8'h00);
    @(posedge clock); wake_up <= 1'b1;
    @(posedge clock); wake_up <= 1'b0;
    @(negedge clock);
    check("awake", {6'h00, sleeping, osc_halt}, 8'h00);
    set_w(8'h0F);
  endtask : t_sleep
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    ew = 8'h00; es = 8'h18;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    t_reset();
    t_xor();
    t_rotate(8'h01, 1'b1);
    t_rotate(8'h80, 1'b0);
    t_sub(8'h05, 8'h03, 1'b1);
    t_sub(8'h03, 8'h03, 1'b0);
    t_sub(8'h00, 8'h01, 1'b1);
    t_sub(8'h10, 8'h01, 1'b0);
    t_swap(1'b0);
    t_swap(1'b1);
    t_dir();
    t_sleep();
    summarize();
  end
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
endmodule : iex_exec_tb
`default_nettype wire
